// file: hw/crf_regs.sv
// cpu programmer register set with flags and vector addressing
// assumes decoder/alu on CLK issue one command per cycle and a wishbone master
`timescale 1ns/1ps
module crf_regs (
  input wire logic CLK,
  input wire logic RESET_N,
  input crf_pkg::crf_cmd_s CMD,
  input wire logic [15:0] INSTR_ADDR,
  input wire logic [7:0] PROG_DATA,
  input wire logic [7:0] STACK_RDATA,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output crf_pkg::crf_out_s CORE_O,
  output logic [15:0] PAIR_WORD,
  output logic [7:0] FLAGS_O
);
  import crf_pkg::*;

  crf_state_s q, d;

  function automatic logic [8:0] stk(input logic [7:0] p);
    stk = {STACK_PAGE[0], p};
  endfunction

  function automatic logic [7:0] nz(input logic [7:0] f, input logic [7:0] r);
    logic [7:0] t;
    t = f;
    t[F_Z] = (r == 8'h00);
    t[F_N] = r[7];
    nz = t;
  endfunction

  logic [7:0] idx_sel;
  logic [8:0] cmp_diff;
  assign idx_sel = CMD.sel_idx2 ? q.idx2 : q.idx1;
  assign cmp_diff = {1'b0, idx_sel} - {1'b0, CMD.data};

  always_comb begin
    d = q;
    d.o.stack_we = 1'b0;
    d.wb_ack = 1'b0;
    d.o.eff_addr = INSTR_ADDR + {8'h00, idx_sel};
    d.o.direct_base = q.flags[F_G] ? {1'b1, 8'h00} : 9'h000;
    d.o.stack_addr = stk(q.sp);
    d.o.prog_addr = q.pc;
    case (q.st)
      VEC_HI: begin
        d.pc[15:8] = PROG_DATA;
        d.st = RUN;
      end
      RUN: begin
        case (CMD.op)
          OP_LD_WORK: begin
            d.work = CMD.data;
            d.flags = nz(q.flags, CMD.data);
          end
          OP_LD_IDX1: begin
            d.idx1 = CMD.data;
            d.flags = nz(q.flags, CMD.data);
          end
          OP_LD_IDX2: begin
            d.idx2 = CMD.data;
            d.flags = nz(q.flags, CMD.data);
          end
          OP_LD_PAIR: begin
            d.idx2 = CMD.word[15:8];
            d.work = CMD.word[7:0];
            d.flags[F_Z] = (CMD.word == 16'h0000);
            d.flags[F_N] = CMD.word[15];
          end
          OP_TXSP: d.sp = q.idx1;
          OP_INC_IDX: begin
            if (CMD.sel_idx2) begin
              d.idx2 = q.idx2 + 8'h01;
              d.flags = nz(q.flags, q.idx2 + 8'h01);
            end else begin
              d.idx1 = q.idx1 + 8'h01;
              d.flags = nz(q.flags, q.idx1 + 8'h01);
            end
          end
          OP_DEC_IDX: begin
            if (CMD.sel_idx2) begin
              d.idx2 = q.idx2 - 8'h01;
              d.flags = nz(q.flags, q.idx2 - 8'h01);
            end else begin
              d.idx1 = q.idx1 - 8'h01;
              d.flags = nz(q.flags, q.idx1 - 8'h01);
            end
          end
          OP_CMP_IDX: begin
            d.flags = nz(q.flags, cmp_diff[7:0]);
            d.flags[F_C] = ~cmp_diff[8];
            d.o.cmp_c = ~cmp_diff[8];
            d.o.cmp_z = (cmp_diff[7:0] == 8'h00);
          end
          OP_ALU: begin
            d.work = CMD.data;
            d.flags = nz(q.flags, CMD.data);
            d.flags[F_C] = CMD.alu_c;
            d.flags[F_H] = CMD.alu_h;
            if (CMD.alu_v) begin
              d.flags[F_V] = 1'b1;
            end
          end
          OP_SHIFT: begin
            d.work = CMD.data;
            d.flags = nz(q.flags, CMD.data);
            d.flags[F_C] = CMD.alu_c;
          end
          OP_PUSH: begin
            d.o.stack_addr = stk(q.sp);
            d.o.stack_we = 1'b1;
            d.sp = q.sp - 8'h01;
          end
          OP_POP: begin
            d.sp = q.sp + 8'h01;
            d.o.stack_addr = stk(q.sp + 8'h01);
          end
          OP_RETI_FLAGS: d.flags = STACK_RDATA;
          OP_EI: d.flags[F_I] = 1'b1;
          OP_DI: d.flags[F_I] = 1'b0;
          OP_OVERFLOW_CLEAR_INSTR: begin
            d.flags[F_V] = 1'b0;
            d.flags[F_H] = 1'b0;
          end
          OP_PAGE_ONE_INSTR: d.flags[F_G] = 1'b1;
          OP_PAGE_ZERO_INSTR: d.flags[F_G] = 1'b0;
          OP_BRK: begin
            d.flags[F_B] = 1'b1;
            d.pc = {TCALL15_VEC[15:5], 5'h1e};
            d.o.prog_addr = {TCALL15_VEC[15:5], 5'h1e};
          end
          OP_IRQ: begin
            d.flags[F_I] = 1'b0;
            d.pc = IRQ0_VEC - {11'h000, CMD.vec_n, 1'b0};
            d.o.prog_addr = IRQ0_VEC - {11'h000, CMD.vec_n, 1'b0};
            d.o.stack_we = 1'b1;
            d.sp = q.sp - 8'h01;
          end
          OP_TABLE_JUMP_INSTR: begin
            d.pc = {TCALL15_VEC[15:5], ~CMD.vec_n, 1'b0};
            d.o.prog_addr = {TCALL15_VEC[15:5], ~CMD.vec_n, 1'b0};
          end
          OP_PAGE_JUMP_INSTR: begin
            d.pc = {PAGE_JUMP_INSTR_BASE[15:8], CMD.data};
            d.o.prog_addr = {PAGE_JUMP_INSTR_BASE[15:8], CMD.data};
          end
          OP_JMP: begin
            d.pc = CMD.word;
            d.o.prog_addr = CMD.word;
          end
          OP_BITT: begin
            d.flags[F_V] = CMD.data[6];
            d.flags[F_N] = CMD.data[7];
            d.flags[F_Z] = ((q.work & CMD.data) == 8'h00);
          end
          OP_PC_INC: d.pc = q.pc + 16'h0001;
          default: ;
        endcase
      end
      default: d.st = RUN;
    endcase
    // wishbone slave: registers only, program memory has no write path
    if (WB_CYC_I && WB_STB_I && !q.wb_ack) begin
      d.wb_ack = 1'b1;
      d.wb_dat = 32'h0000_0000;
      case (WB_ADR_I)
        A_WORK: d.wb_dat[7:0] = q.work;
        A_IDX1: d.wb_dat[7:0] = q.idx1;
        A_IDX2: d.wb_dat[7:0] = q.idx2;
        A_SP: d.wb_dat[7:0] = q.sp;
        A_PCL: d.wb_dat[7:0] = q.pc[7:0];
        A_PCH: d.wb_dat[7:0] = q.pc[15:8];
        A_FLAGS: d.wb_dat[7:0] = q.flags;
        A_RPAGE: d.wb_dat[7:0] = q.rpage;
        default: d.wb_dat = 32'h0000_0000;
      endcase
      if (WB_WE_I && WB_SEL_I[0]) begin
        case (WB_ADR_I)
          A_SP: d.sp = WB_DAT_I[7:0];
          A_RPAGE: d.rpage = WB_DAT_I[7:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q <= '0;
      q.st <= VEC_HI;
      q.pc <= PC_RESET;
      q.sp <= SP_RESET;
      q.flags <= FLAGS_RESET;
      q.o.prog_addr <= RESET_VEC + 16'h0001;
    end else begin
      q <= d;
      if (q.st == VEC_HI) begin
        q.o.prog_addr <= RESET_VEC;
      end
    end
  end

  assign WB_DAT_O = q.wb_dat;
  assign WB_ACK_O = q.wb_ack;
  assign CORE_O = q.o;
  assign PAIR_WORD = {q.idx2, q.work};
  assign FLAGS_O = q.flags;

  a_irq_gate_clr: assert property (@(posedge CLK) disable iff (!RESET_N)
    (q.st == RUN && CMD.op == OP_IRQ) |=> !FLAGS_O[F_I]) else $error("irq did not clear gate");
  a_push_sp_dec: assert property (@(posedge CLK) disable iff (!RESET_N)
    (q.st == RUN && CMD.op == OP_PUSH) |=> (q.sp == $past(q.sp) - 8'h01) && CORE_O.stack_we)
    else $error("push order wrong");
  a_pop_sp_inc: assert property (@(posedge CLK) disable iff (!RESET_N)
    (q.st == RUN && CMD.op == OP_POP) |=> CORE_O.stack_addr == {1'b1, q.sp}) else $error("pop order wrong");
  a_pc_wraps: assert property (@(posedge CLK) disable iff (!RESET_N)
    (q.st == RUN && CMD.op == OP_PC_INC && q.pc == 16'hffff) |=> q.pc == 16'h0000) else $error("pc no wrap");
  a_zero_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
    (q.st == RUN && CMD.op == OP_LD_WORK) |=> FLAGS_O[F_Z] == (q.work == 8'h00)) else $error("zero flag");
  a_bit_test: assert property (@(posedge CLK) disable iff (!RESET_N)
    (q.st == RUN && CMD.op == OP_BITT) |=> FLAGS_O[7:6] == $past(CMD.data[7:6])) else $error("bit test");
  a_page_sel: assert property (@(posedge CLK) disable iff (!RESET_N)
    (q.st == RUN && CMD.op == OP_PAGE_ZERO_INSTR) |=> ##1 CORE_O.direct_base == 9'h000) else $error("page zero");
  a_brk_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
    (q.st == RUN && CMD.op == OP_BRK) |=> FLAGS_O[F_B]) else $error("break flag");
  a_wb_ack_one: assert property (@(posedge CLK) disable iff (!RESET_N)
    WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  c_irq: cover property (@(posedge CLK) disable iff (!RESET_N) q.st == RUN && CMD.op == OP_IRQ);
  c_wrap: cover property (@(posedge CLK) disable iff (!RESET_N) q.pc == 16'hffff ##1 q.pc == 16'h0000);
  c_wb_write: cover property (@(posedge CLK) disable iff (!RESET_N) WB_ACK_O && WB_WE_I);
endmodule

// file: shared/crf_pkg.sv
// constants, types and structs of the cpu register file
// assumes a decoder/alu on the same clock drives the command struct
// Operation
// - 8-bit work register pairs with second offset register as 16-bit word.
// - indexed modes add selected offset register to instruction address.
// - offset registers support increment, decrement and compare; only the first transfers to the stack pointer.
// - 8-bit stack pointer addresses stack page 0x100 to 0x1ff.
// - save writes then decrements; restore increments then reads.
// - 16-bit program counter of two bytes; reset loads only the high byte from 0xffff, low byte stays 0x00.
// - program address wraps from 0xffff to 0x0000.
// - program memory is read-only; no write port exists.
// - carry takes alu carry or borrow and shift/rotate carry.
// - zero flag set on zero result, cleared on nonzero.
// - interrupt gate masks irqs; cleared on service, set/cleared by instructions.
// - nibble carry from alu bit 3; reloaded by every alu op, also cleared by overflow-clear.
// - soft break sets break flag to tell it from table jump.
// - direct page flag selects page 0 or 0x100-0x1ff; set/clear instructions.
// - with page flag clear, direct access uses page zero regardless of page reg.
// - overflow flag on signed overflow; cleared by overflow-clear; bit-test copies bit 6.
// - sign flag follows result bit 7; bit-test copies memory bit 7.
// - page jump is 2 bytes, targets fixed subroutine area.
// - table jump reads 2-byte entries near top of program memory.
// - interrupts vector via fixed 2-byte slots, int0 at 0xfffc, int1 at 0xfffa.
package crf_pkg;
  localparam logic [15:0] RESET_VEC = 16'hfffe;
  localparam logic [15:0] IRQ0_VEC = 16'hfffc;
  localparam logic [15:0] TCALL15_VEC = 16'hffc0;
  localparam logic [15:0] PAGE_JUMP_INSTR_BASE = 16'hff00;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] REG_RESET = 8'h00;
  // flag bit positions
  localparam int F_C = 0;
  localparam int F_Z = 1;
  localparam int F_I = 2;
  localparam int F_H = 3;
  localparam int F_B = 4;
  localparam int F_G = 5;
  localparam int F_V = 6;
  localparam int F_N = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // wishbone map, word offsets
  localparam logic [3:0] A_WORK = 4'h0;
  localparam logic [3:0] A_IDX1 = 4'h1;
  localparam logic [3:0] A_IDX2 = 4'h2;
  localparam logic [3:0] A_SP = 4'h3;
  localparam logic [3:0] A_PCL = 4'h4;
  localparam logic [3:0] A_PCH = 4'h5;
  localparam logic [3:0] A_FLAGS = 4'h6;
  localparam logic [3:0] A_RPAGE = 4'h7;

  typedef enum logic [4:0] {
    OP_NONE, OP_LD_WORK, OP_LD_IDX1, OP_LD_IDX2, OP_LD_PAIR, OP_TXSP, OP_INC_IDX, OP_DEC_IDX,
    OP_CMP_IDX, OP_ALU, OP_SHIFT, OP_PUSH, OP_POP, OP_EI, OP_DI, OP_OVERFLOW_CLEAR_INSTR, OP_PAGE_ONE_INSTR, OP_PAGE_ZERO_INSTR,
    OP_BRK, OP_IRQ, OP_TABLE_JUMP_INSTR, OP_PAGE_JUMP_INSTR, OP_JMP, OP_BITT, OP_RETI_FLAGS, OP_PC_INC
  } crf_op_e;

  typedef enum logic {RUN, VEC_HI} crf_state_e;

  typedef struct packed {
    crf_op_e op;
    logic sel_idx2;   // offset register select
    logic [7:0] data;
    logic [15:0] word;
    logic alu_c;
    logic alu_h;
    logic alu_v;
    logic [3:0] vec_n; // irq source or table index
  } crf_cmd_s;

  typedef struct packed {
    logic [15:0] eff_addr;
    logic [8:0] stack_addr;
    logic stack_we;
    logic [8:0] direct_base;
    logic [15:0] prog_addr;
    logic cmp_c;
    logic cmp_z;
  } crf_out_s;

  typedef struct packed {
    crf_state_e st;
    logic [7:0] work;
    logic [7:0] idx1;
    logic [7:0] idx2;
    logic [7:0] sp;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [7:0] rpage;
    crf_out_s o;
    logic [31:0] wb_dat;
    logic wb_ack;
  } crf_state_s;
endpackage

// file: tb/crf_core_model.sv
// stand-in for the decoder and alu: issues one command per call
// assumes the register set takes CMD at each rising CLK
`timescale 1ns/1ps
module crf_core_model (
  input wire logic CLK,
  output crf_pkg::crf_cmd_s CMD,
  output logic [15:0] INSTR_ADDR,
  output logic [7:0] PROG_DATA,
  output logic [7:0] STACK_RDATA
);
  import crf_pkg::*;
  initial begin
    CMD = '0;
    INSTR_ADDR = 16'h0420;
    PROG_DATA = 8'hc5;
    STACK_RDATA = 8'h5a;
  end
  // command stands one cycle, then the bus returns to idle
  task automatic issue(input crf_op_e op, input logic [7:0] d = 8'h00, input logic [15:0] w = 16'h0000,
                       input logic [3:0] n = 4'h0, input logic [2:0] chv = 3'h0, input logic s2 = 1'b0);
    @(posedge CLK);
    CMD <= '{op: op, sel_idx2: s2, data: d, word: w, alu_c: chv[2], alu_h: chv[1], alu_v: chv[0], vec_n: n};
    @(posedge CLK);
    CMD.op <= OP_NONE;
    #1;
  endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the cpu register set
// assumes the core model drives commands and a wishbone master task reaches the registers
`timescale 1ns/1ps
module tb;
  import crf_pkg::*;
  logic CLK, RESET_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [3:0] WB_ADR_I, WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O;
  logic [15:0] INSTR_ADDR, PAIR_WORD;
  logic [7:0] PROG_DATA, STACK_RDATA, FLAGS_O, q;
  crf_cmd_s CMD;
  crf_out_s CORE_O;
  int bad_count = 0;
  int n_compared = 0;
  wire [4:0] nvhzc = {FLAGS_O[F_N], FLAGS_O[F_V], FLAGS_O[F_H], FLAGS_O[F_Z], FLAGS_O[F_C]};
  crf_core_model i_core (.CLK(CLK), .CMD(CMD), .INSTR_ADDR(INSTR_ADDR), .PROG_DATA(PROG_DATA),
    .STACK_RDATA(STACK_RDATA));
  crf_regs i_dut (.CLK(CLK), .RESET_N(RESET_N), .CMD(CMD), .INSTR_ADDR(INSTR_ADDR), .PROG_DATA(PROG_DATA),
    .STACK_RDATA(STACK_RDATA), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .CORE_O(CORE_O), .PAIR_WORD(PAIR_WORD), .FLAGS_O(FLAGS_O));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  // classic cycle: hold until ack is sampled at a rising edge, take data and release at that edge
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge CLK);
    {WB_CYC_I, WB_STB_I, WB_WE_I} <= {2'b11, we};
    WB_ADR_I <= a;
    WB_DAT_I <= {24'h000000, d};
    i = 0;
    do begin
      @(posedge CLK);
      i++;
    end while (WB_ACK_O !== 1'b1 && i < 20);
    if (WB_ACK_O !== 1'b1) begin
      bad_count++;
      summarize();
    end
    q = WB_DAT_O[7:0];
    {WB_CYC_I, WB_STB_I, WB_WE_I} <= 3'b000;
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, {8'h00, e}, {8'h00, q});
  endtask
  initial begin
    crf_op_e fo[5] = '{OP_EI, OP_DI, OP_PAGE_ONE_INSTR, OP_PAGE_ZERO_INSTR, OP_BRK};
    int fb[5] = '{F_I, F_I, F_G, F_G, F_B};
    logic fv[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    RESET_N = 1'b0;
    {WB_CYC_I, WB_STB_I, WB_WE_I} = 3'b000;
    WB_ADR_I = 4'h0;
    WB_DAT_I = 32'h00000000;
    WB_SEL_I = 4'h1;
    repeat (6) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (2) @(posedge CLK);
    rdc("pc high", A_PCH, 8'hc5);
    rdc("flags", A_FLAGS, FLAGS_RESET);
    rdc("unmapped", 4'hf, 8'h00);
    wb(1'b1, A_SP, 8'hff);
    rdc("sp", A_SP, 8'hff);
    wb(1'b1, A_WORK, 8'h77);
    rdc("work", A_WORK, REG_RESET);
    $display("test reset and bus done");
    i_core.issue(OP_LD_WORK, 8'h80);
    chk("ld n", 5'b10000, nvhzc & 5'b10010);
    i_core.issue(OP_LD_WORK, 8'h34);
    i_core.issue(OP_LD_IDX2, 8'h12);
    chk("pair", 16'h1234, PAIR_WORD);
    i_core.issue(OP_LD_IDX1, 8'h05);
    i_core.issue(OP_NONE);
    chk("eff x", 16'h0425, CORE_O.eff_addr);
    i_core.issue(OP_NONE, .s2(1'b1));
    chk("eff y", 16'h0432, CORE_O.eff_addr);
    i_core.issue(OP_INC_IDX);
    i_core.issue(OP_DEC_IDX);
    i_core.issue(OP_DEC_IDX);
    rdc("idx1", A_IDX1, 8'h04);
    i_core.issue(OP_CMP_IDX, 8'h04);
    chk("cmp eq", 1'b1, CORE_O.cmp_z);
    chk("cmp eq c", 1'b1, CORE_O.cmp_c);
    i_core.issue(OP_CMP_IDX, 8'h05);
    chk("cmp ne", 1'b0, CORE_O.cmp_z);
    chk("cmp ne c", 1'b0, CORE_O.cmp_c);
    $display("test offset regs done");
    i_core.issue(OP_PUSH, 8'h99);
    chk("push1", 10'h3ff, {CORE_O.stack_we, CORE_O.stack_addr});
    i_core.issue(OP_PUSH, 8'h98);
    chk("push2", 10'h3fe, {CORE_O.stack_we, CORE_O.stack_addr});
    i_core.issue(OP_POP);
    chk("pop", 10'h1fe, {CORE_O.stack_we, CORE_O.stack_addr});
    rdc("sp after", A_SP, 8'hfe);
    $display("test stack done");
    for (int k = 0; k < 5; k++) begin
      i_core.issue(fo[k]);
      chk("flag op", fv[k], FLAGS_O[fb[k]]);
    end
    wb(1'b1, A_RPAGE, 8'h03);
    i_core.issue(OP_PAGE_ZERO_INSTR);
    i_core.issue(OP_NONE);
    chk("page0", 9'h000, CORE_O.direct_base);
    i_core.issue(OP_PAGE_ONE_INSTR);
    i_core.issue(OP_NONE);
    chk("page1", 9'h100, CORE_O.direct_base);
    i_core.issue(OP_ALU, 8'h00, .chv(3'b110));
    chk("alu1", 5'b00111, nvhzc);
    i_core.issue(OP_ALU, 8'h80, .chv(3'b011));
    chk("alu2", 5'b11100, nvhzc);
    i_core.issue(OP_ALU, 8'h01);
    chk("alu3", 5'b01000, nvhzc);
    i_core.issue(OP_OVERFLOW_CLEAR_INSTR);
    chk("overflow_clear_instr", 5'b00000, nvhzc);
    i_core.issue(OP_BITT, 8'hc0);
    chk("bit c0", 2'b11, nvhzc[4:3]);
    i_core.issue(OP_BITT, 8'h40);
    chk("bit 40", 2'b01, nvhzc[4:3]);
    i_core.issue(OP_SHIFT, 8'h02, .chv(3'b100));
    chk("shift c", 1'b1, FLAGS_O[F_C]);
    $display("test flags done");
    for (int n = 0; n < 2; n++) begin
      i_core.issue(OP_EI);
      i_core.issue(OP_IRQ, .n(n[3:0]));
      chk("irq vec", IRQ0_VEC - 16'(2 * n), CORE_O.prog_addr);
      chk("irq gate", 1'b0, FLAGS_O[F_I]);
    end
    for (int n = 0; n < 16; n += 15) begin
      i_core.issue(OP_TABLE_JUMP_INSTR, .n(n[3:0]));
      chk("table_jump_instr", 16'hffc0 + 16'(2 * (15 - n)), CORE_O.prog_addr);
    end
    i_core.issue(OP_PAGE_JUMP_INSTR, 8'h35);
    chk("page_jump_instr", 16'hff35, CORE_O.prog_addr);
    i_core.issue(OP_JMP, .w(16'hffff));
    i_core.issue(OP_PC_INC);
    rdc("pcl wrap", A_PCL, 8'h00);
    rdc("pch wrap", A_PCH, 8'h00);
    i_core.issue(OP_RETI_FLAGS);
    chk("reti", 8'h5a, FLAGS_O);
    $display("test program flow done");
    summarize();
  end
endmodule
